// File: dv/dorg_gearbox_test.sv
// testbench of the output register gearbox
`default_nettype none
module dorg_gearbox_test
    import dorg_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic ref_clk = 1'b0;
    logic sys_rst = 1'b1;
    dorg_word_s in_data = DORG_WORD_RESET;
    logic in_valid = 1'b0;
    dorg_mode_e mode = DORG_MODE_SDR;
    logic use_latch = 1'b0;
    logic wpc0 = 1'b0;
    logic wpc1 = 1'b0;
    logic in_ready, pin_data, pin_oe, sch, refused, ref_top, ref_bot, rx_valid;
    logic [3:0] rx_word;
    logic [1:0] tb_slot = 2'h0;
    logic sch_d = 1'b0;
    logic saw_full = 1'b0;
    logic [3:0] rxq[$];
    int errors = 0;
    int checks_done = 0;
    // ====================================================================
    // clock, write-phase select and capture of received groups
    always #12.5 ref_clk = ~ref_clk;
    // phase select leads its use by two cycles through the synchroniser
    always @(negedge ref_clk) begin
        tb_slot = (sch && !sch_d) ? 2'h1 : tb_slot + 2'h1;
        sch_d = sch;
        {wpc1, wpc0} = tb_slot + 2'h2;
    end
    always @(posedge ref_clk) begin
        if (rx_valid === 1'b1) rxq.push_back(rx_word);
    end
    // ====================================================================
    // instances: left edge drives the receiver, top and bottom show fallbacks
    dorg_gearbox dorg_gearbox_inst (.ref_clk(ref_clk), .sys_rst(sys_rst),
        .in_data(in_data), .in_valid(in_valid), .in_ready(in_ready), .mode(mode),
        .sdr_use_latch(use_latch), .write_phase_clock_zero(wpc0),
        .write_phase_clock_one(wpc1), .pin_data(pin_data), .pin_oe(pin_oe),
        .sys_clk_high(sch), .mode_refused(refused));
    dorg_gearbox #(.EDGE(DORG_EDGE_TOP)) dorg_gearbox_top_inst (.ref_clk(ref_clk),
        .sys_rst(sys_rst), .in_data(in_data), .in_valid(in_valid), .in_ready(),
        .mode(mode), .sdr_use_latch(use_latch), .write_phase_clock_zero(wpc0),
        .write_phase_clock_one(wpc1), .pin_data(), .pin_oe(), .sys_clk_high(),
        .mode_refused(ref_top));
    dorg_gearbox #(.EDGE(DORG_EDGE_BOTTOM)) dorg_gearbox_bot_inst (.ref_clk(ref_clk),
        .sys_rst(sys_rst), .in_data(in_data), .in_valid(in_valid), .in_ready(),
        .mode(mode), .sdr_use_latch(use_latch), .write_phase_clock_zero(wpc0),
        .write_phase_clock_one(wpc1), .pin_data(), .pin_oe(), .sys_clk_high(),
        .mode_refused(ref_bot));
    dorg_rx_model dorg_rx_model_inst (.ref_clk(ref_clk), .sys_rst(sys_rst),
        .pin_data(pin_data), .pin_oe(pin_oe), .rx_word(rx_word), .rx_valid(rx_valid));
    // ====================================================================
    // tasks
    task automatic end_sim();
        $display("checks_done=%0d errors=%0d", checks_done, errors);
        if (errors == 0 && checks_done > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    task automatic check(input logic [3:0] got, input logic [3:0] exp);
        checks_done++;
        if (got !== exp) begin
            errors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // offer one word and hold it until the fifo takes it
    task automatic push(input dorg_word_s w);
        int n;
        in_data = w;
        in_valid = 1'b1;
        n = 0;
        do begin
            @(posedge ref_clk);
            n++;
            if (in_ready !== 1'b1) saw_full = 1'b1;
            if (n > 200) begin
                errors++;
                end_sim();
            end
        end while (in_ready !== 1'b1);
        @(negedge ref_clk);
    endtask
    // send n words back to back in one mode and judge the serial groups
    task automatic stream(input dorg_mode_e m, input logic l, input int n);
        dorg_word_s w;
        logic [3:0] e;
        int k;
        mode = m;
        use_latch = l;
        rxq.delete();
        repeat (8) @(negedge ref_clk);
        for (int i = 0; i < n; i++) push(4'(i * 7 + 1));
        in_valid = 1'b0;
        k = 0;
        while (rxq.size() < n) begin
            @(negedge ref_clk);
            k++;
            if (k > 400) begin
                errors++;
                end_sim();
            end
        end
        for (int i = 0; i < n; i++) begin
            w = 4'(i * 7 + 1);
            case (m)
                DORG_MODE_SDR: e = {4{w.rise_data_first}};
                DORG_MODE_DDR: e = {{2{w.rise_data_first}}, {2{w.fall_data_first}}};
                default: e = {w.rise_data_first, w.rise_data_second,
                    w.fall_data_first, w.fall_data_second};
            endcase
            check(rxq[i], e);
        end
    endtask
    // ====================================================================
    // main sequence
    initial begin
        repeat (8) @(negedge ref_clk);
        check({pin_oe, pin_data, in_ready, refused}, 4'h0);
        sys_rst = 1'b0;
        stream(DORG_MODE_SDR, 1'b0, 24);
        check({3'h0, saw_full}, 4'h1);
        stream(DORG_MODE_SDR, 1'b1, 6);
        check({3'h0, ref_bot}, 4'h0);
        stream(DORG_MODE_DDR, 1'b0, 8);
        check({2'h0, refused, ref_bot}, 4'h1);
        stream(DORG_MODE_GEAR, 1'b0, 8);
        check({2'h0, refused, ref_top}, 4'h1);
        mode = dorg_mode_e'(2'h3);
        repeat (8) @(negedge ref_clk);
        check({2'h0, refused, ref_bot}, 4'h3);
        end_sim();
    end
endmodule
`default_nettype wire

// File: dv/dorg_rx_model.sv
// receiver model that gathers serial pin bits into four-bit groups
`default_nettype none
module dorg_rx_model (
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic pin_data,
    input wire logic pin_oe,
    output logic [3:0] rx_word,
    output logic rx_valid
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [1:0] cnt;
    logic [3:0] sh;
    // ====================================================================
    // sample every enabled bit, the oldest bit ends in the msb
    always_ff @(posedge ref_clk) begin
        rx_valid <= 1'b0;
        if (sys_rst) begin
            cnt <= 2'h0;
            sh <= 4'h0;
            rx_word <= 4'h0;
        end else if (pin_oe) begin
            sh <= {sh[2:0], pin_data};
            cnt <= cnt + 2'h1;
            if (cnt == 2'h3) begin
                rx_word <= {sh[2:0], pin_data};
                rx_valid <= 1'b1;
            end
        end
    end
endmodule
`default_nettype wire

// File: hdl/dorg_gearbox.sv
// fifo and output register gearbox of one programmable_pin_cell
`default_nettype none

// ========================================================================
// fifo with registered full and empty flags
module dorg_fifo #(
    parameter int WIDTH = 4,
    parameter int DEPTH = 16
) (
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic [WIDTH-1:0] in_data,
    input wire logic in_valid,
    output logic in_ready,
    output logic [WIDTH-1:0] out_data,
    output logic out_valid,
    input wire logic out_ready
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [AW:0] count;
    logic push;
    logic pop;
    logic [AW:0] next_count;

    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;
    assign out_data = mem[rd_ptr];

    always_comb begin
        next_count = count;
        if (push && !pop) begin
            next_count = count + 1'b1;
        end else if (pop && !push) begin
            next_count = count - 1'b1;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (push) begin
            mem[wr_ptr] <= in_data;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
            in_ready <= 1'b0;
            out_valid <= 1'b0;
        end else begin
            wr_ptr <= push ? wr_ptr + 1'b1 : wr_ptr;
            rd_ptr <= pop ? rd_ptr + 1'b1 : rd_ptr;
            count <= next_count;
            in_ready <= (next_count != (AW + 1)'(DEPTH));
            out_valid <= (next_count != '0);
        end
    end
endmodule

// ========================================================================
// What this block does
// - sdr mode: rise_data_first through one flip-flop or latch to the pin
// - ddr mode: capture two inputs at rise, latch one the next phase
// - ddr mode: output mux on the capture clock alternates both paths
// - gear mode: register four streams at rise, latch two of them
// - gear mode: serialise at edge rate, mux steered by write-phase clocks
// - write-phase clocks come from outside and move data to edge domain
// - left and right edges offer sdr, ddr and double gear mode
// - top edge as left and right but without double gear mode
// - bottom edge offers sdr registers only, no generic ddr
module dorg_gearbox
    import dorg_pkg::*;
#(
    parameter logic [1:0] EDGE = DORG_EDGE_LEFT
) (
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire dorg_word_s in_data,
    input wire logic in_valid,
    output logic in_ready,
    input wire dorg_mode_e mode,
    input wire logic sdr_use_latch,
    input wire logic write_phase_clock_zero,
    input wire logic write_phase_clock_one,
    output logic pin_data,
    output logic pin_oe,
    output logic sys_clk_high,
    output logic mode_refused
);
    logic [1:0] slot;
    logic head_valid;
    logic head_ready;
    dorg_word_s head;
    dorg_word_s cap;
    logic cap_valid;
    logic lat_fall_first;
    logic lat_fall_second;
    dorg_mode_e eff_mode;
    dorg_mode_e next_eff_mode;
    logic [1:0] wpc_meta;
    logic [1:0] wpc_sync;
    logic gear_pick;
    logic next_pin;

    dorg_fifo #(.WIDTH($bits(dorg_word_s)), .DEPTH(DORG_FIFO_DEPTH)) u_fifo (
        .ref_clk(ref_clk),
        .sys_rst(sys_rst),
        .in_data(in_data),
        .in_valid(in_valid),
        .in_ready(in_ready),
        .out_data(head),
        .out_valid(head_valid),
        .out_ready(head_ready)
    );

    // one word drained per system period, so the fifo fills when fed faster
    assign head_ready = (slot == DORG_SLOT_LAST);

    // ====================================================================
    // system period slot counter
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            slot <= DORG_SLOT_RISE;
            sys_clk_high <= 1'b0;
        end else begin
            slot <= slot + 2'h1;
            // high in the same cycles that the pin carries the rise datum in ddr mode
            sys_clk_high <= (slot == DORG_SLOT_RISE) || (slot == DORG_SLOT_LATCH);
        end
    end

    // ====================================================================
    // mode allowed by the chip edge, taken at a period boundary
    always_comb begin
        next_eff_mode = mode;
        if (EDGE == DORG_EDGE_BOTTOM) begin
            next_eff_mode = DORG_MODE_SDR;
        end else if (EDGE == DORG_EDGE_TOP && mode == DORG_MODE_GEAR) begin
            next_eff_mode = DORG_MODE_DDR;
        end else if (mode != DORG_MODE_DDR && mode != DORG_MODE_GEAR) begin
            next_eff_mode = DORG_MODE_SDR;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            eff_mode <= DORG_MODE_SDR;
            mode_refused <= 1'b0;
        end else if (slot == DORG_SLOT_LAST) begin
            eff_mode <= next_eff_mode;
            mode_refused <= (next_eff_mode != mode);
        end
    end

    // ====================================================================
    // rising-edge capture of all four streams
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            cap <= DORG_WORD_RESET;
            cap_valid <= 1'b0;
        end else if (slot == DORG_SLOT_LAST) begin
            cap <= head_valid ? head : DORG_WORD_RESET;
            cap_valid <= head_valid;
        end
    end

    // latch stage passes the fall data into the low half of the period
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            lat_fall_first <= 1'b0;
            lat_fall_second <= 1'b0;
        end else if (slot == DORG_SLOT_LATCH) begin
            lat_fall_first <= cap.fall_data_first;
            lat_fall_second <= cap.fall_data_second;
        end
    end

    // ====================================================================
    // write-phase clocks arrive from the strobe write control
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            wpc_meta <= 2'h0;
            wpc_sync <= 2'h0;
        end else begin
            wpc_meta <= {write_phase_clock_one, write_phase_clock_zero};
            wpc_sync <= wpc_meta;
        end
    end

    always_comb begin
        case (wpc_sync)
            2'h0: gear_pick = cap.rise_data_first;
            2'h1: gear_pick = cap.rise_data_second;
            2'h2: gear_pick = lat_fall_first;
            2'h3: gear_pick = lat_fall_second;
            default: gear_pick = 1'b0;
        endcase
    end

    // ====================================================================
    // output mux and pin register
    always_comb begin
        next_pin = pin_data;
        case (eff_mode)
            DORG_MODE_SDR: begin
                if (slot == DORG_SLOT_RISE || (sdr_use_latch && slot == DORG_SLOT_LATCH)) begin
                    next_pin = cap.rise_data_first;
                end
            end
            DORG_MODE_DDR: begin
                next_pin = slot[1] ? lat_fall_first : cap.rise_data_first;
            end
            DORG_MODE_GEAR: next_pin = gear_pick;
            default: next_pin = 1'b0;
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            pin_data <= 1'b0;
            pin_oe <= 1'b0;
        end else begin
            pin_data <= next_pin;
            pin_oe <= cap_valid;
        end
    end

    // ====================================================================
    // checks
    a_sdr_path: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (eff_mode == DORG_MODE_SDR && slot == 2'h2) |-> pin_data == cap.rise_data_first)
        else $error("sdr pin does not show captured rise data");

    a_capture_word: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (slot == 2'h3 && head_valid) |=> cap == $past(head) ##3 cap == $past(head, 4))
        else $error("captured word lost or changed inside the period");

    a_latch_fall: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (slot == 2'h1) |=> (lat_fall_first == $past(cap.fall_data_first)
            && lat_fall_second == $past(cap.fall_data_second)))
        else $error("fall data not latched");

    sequence s_ddr_high;
        pin_data == cap.rise_data_first && sys_clk_high;
    endsequence
    sequence s_ddr_low;
        pin_data == lat_fall_first && !sys_clk_high;
    endsequence
    a_ddr_halves: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (slot == 2'h1 && eff_mode == DORG_MODE_DDR && next_eff_mode == DORG_MODE_DDR)
            |-> s_ddr_high ##2 s_ddr_low)
        else $error("ddr halves out of order");

    a_gear_select: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (eff_mode == DORG_MODE_GEAR && slot != 2'h3) |=> pin_data == $past(gear_pick))
        else $error("gear output not steered by write-phase clocks");

    a_wpc_sync: assert property (@(posedge ref_clk) disable iff (sys_rst)
        1'b1 |-> ##2 wpc_sync == $past({write_phase_clock_one, write_phase_clock_zero}, 2))
        else $error("write-phase clocks not two stages deep");

    a_edge_side: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (EDGE < DORG_EDGE_TOP && slot == 2'h3 && mode == DORG_MODE_GEAR)
            |=> eff_mode == DORG_MODE_GEAR && !mode_refused)
        else $error("side edge refused gear mode");

    a_edge_top: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (EDGE == DORG_EDGE_TOP) |-> eff_mode != DORG_MODE_GEAR)
        else $error("top edge entered gear mode");

    a_edge_bottom: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (EDGE == DORG_EDGE_BOTTOM) |-> eff_mode == DORG_MODE_SDR)
        else $error("bottom edge left sdr mode");
endmodule
`default_nettype wire

// File: hdl/dorg_pkg.sv
// shared types and constants of the ddr output register gearbox
`default_nettype none
package dorg_pkg;
    // ====================================================================
    // output modes and chip edges
    typedef enum logic [1:0] {
        DORG_MODE_SDR,
        DORG_MODE_DDR,
        DORG_MODE_GEAR
    } dorg_mode_e;

    localparam logic [1:0] DORG_EDGE_LEFT = 2'h0;
    localparam logic [1:0] DORG_EDGE_RIGHT = 2'h1;
    localparam logic [1:0] DORG_EDGE_TOP = 2'h2;
    localparam logic [1:0] DORG_EDGE_BOTTOM = 2'h3;

    // ====================================================================
    // one system period is four reference cycles (four edge-clock slots)
    localparam logic [1:0] DORG_SLOT_RISE = 2'h0;
    localparam logic [1:0] DORG_SLOT_LATCH = 2'h1;
    localparam logic [1:0] DORG_SLOT_LAST = 2'h3;
    localparam int DORG_FIFO_DEPTH = 16;

    // ====================================================================
    // one system-clock word of the four core data streams
    typedef struct packed {
        logic rise_data_first;
        logic fall_data_first;
        logic rise_data_second;
        logic fall_data_second;
    } dorg_word_s;

    localparam dorg_word_s DORG_WORD_RESET = 4'h0;
endpackage
`default_nettype wire
